// ### vcac_pkg.sv
// Package: constants and carriers for the VC1 arbitration capability word
`default_nettype none
package vcac_pkg;

  // ==========================================================================
  // Configuration access geometry
  // ==========================================================================
  localparam int unsigned ADDR_W   = 12;   // Extended configuration space
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned BE_W     = 4;
  localparam int unsigned WORD_LSB = 2;    // Dword granularity of a register

  localparam logic [ADDR_W-1:0] CAP_OFFSET = 12'h16C;
  localparam logic [DATA_W-1:0] CAP_RESET  = 32'h077F0011;

  // ==========================================================================
  // Field positions and widths
  // ==========================================================================
  localparam int unsigned TBL_POS_LSB  = 24;
  localparam int unsigned TBL_POS_W    = 8;
  localparam int unsigned RSVD_HI_BIT  = 23;
  localparam int unsigned SLOTS_LSB    = 16;
  localparam int unsigned SLOTS_W      = 7;
  localparam int unsigned SNOOP_BIT    = 15;
  localparam int unsigned SWITCHED_BIT = 14;
  localparam int unsigned RSVD_LO_LSB  = 8;
  localparam int unsigned RSVD_LO_W    = 6;
  localparam int unsigned SUPPORT_LSB  = 0;
  localparam int unsigned SUPPORT_W    = 8;
  localparam int unsigned CHOICE_W     = 3;

  // ==========================================================================
  // Field values
  // ==========================================================================
  localparam logic [TBL_POS_W-1:0] TBL_POS_VAL    = 8'h07;
  localparam int unsigned          TBL_UNIT_BYTES = 16;   // Table offset unit
  localparam int unsigned          TBL_BYTES      = 112;  // Table start in bytes
  localparam logic [SLOTS_W-1:0]   SLOTS_VAL      = 7'h7F;
  localparam int unsigned          SLOTS_COUNT    = 128;  // Field holds count - 1
  localparam logic                 RSVD_HI_VAL    = 1'h0;
  localparam logic                 SNOOP_VAL      = 1'h0;
  localparam logic                 SWITCHED_VAL   = 1'h0;
  localparam logic [RSVD_LO_W-1:0] RSVD_LO_VAL    = 6'h00;
  localparam logic [SUPPORT_W-1:0] SUPPORT_VAL    = 8'h11;

  // ==========================================================================
  // Arbitration scheme bit positions within the support mask
  // ==========================================================================
  typedef enum logic [CHOICE_W-1:0] {
    VCAC_FIXED_RR   = 3'h0,
    VCAC_WRR_32     = 3'h1,
    VCAC_WRR_64     = 3'h2,
    VCAC_WRR_128    = 3'h3,
    VCAC_TWRR_128   = 3'h4,
    VCAC_WRR_256    = 3'h5,
    VCAC_RSVD_6     = 3'h6,
    VCAC_RSVD_7     = 3'h7
  } vcac_scheme_t;

  // ==========================================================================
  // Configuration request and answer carriers
  // ==========================================================================
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
  } vcac_cfg_req_t;

  typedef struct packed {
    logic              ack;
    logic              hit;
    logic [DATA_W-1:0] rdata;
  } vcac_cfg_rsp_t;

endpackage : vcac_pkg
`default_nettype wire

// ### vcac_word_build.sv
// Assembles the capability word from its field values
`timescale 1ns/10ps
`default_nettype none
module vcac_word_build #(
  parameter logic [vcac_pkg::TBL_POS_W-1:0] TABLE_POSITION = vcac_pkg::TBL_POS_VAL,
  parameter logic [vcac_pkg::SLOTS_W-1:0]   TIME_SLOTS     = vcac_pkg::SLOTS_VAL,
  parameter logic [vcac_pkg::SUPPORT_W-1:0] SCHEME_SUPPORT = vcac_pkg::SUPPORT_VAL
) (
  // Assembled word
  output wire logic [vcac_pkg::DATA_W-1:0] word_out
);
  import vcac_pkg::*;

  // ==========================================================================
  // Field packing
  // ==========================================================================
  // Reserved and fixed-zero fields are constants so no write path can reach them
  assign word_out = {TABLE_POSITION,
                     RSVD_HI_VAL,
                     TIME_SLOTS,
                     SNOOP_VAL,
                     SWITCHED_VAL,
                     RSVD_LO_VAL,
                     SCHEME_SUPPORT};

endmodule : vcac_word_build
`default_nettype wire

// ### vcac_capability.sv
// VC1 arbitration capability word: read-only configuration register
//
// Functional notes
// - Word at offset 16Ch reads 077F0011h; writes never change it.
// - Bits 31:24 read 07h: arbitration table 112 bytes into capability.
// - Reserved bit 23 always reads zero.
// - Bits 22:16 read 7Fh: all 128 time slots for time-based WRR.
// - Bit 15, snoop rejection, reads zero; not a root port.
// - Bit 14 reads zero: channel not limited to switched traffic.
// - Reserved bits 13:8 always read zero.
// - Bits 7:0 are a one-bit-per-scheme arbitration support mask.
// - Support mask reads 11h: fixed round-robin and time-based WRR 128.
`timescale 1ns/10ps
`default_nettype none
module vcac_capability #(
  parameter logic [vcac_pkg::TBL_POS_W-1:0] TABLE_POSITION = vcac_pkg::TBL_POS_VAL,
  parameter logic [vcac_pkg::SLOTS_W-1:0]   TIME_SLOTS     = vcac_pkg::SLOTS_VAL,
  parameter logic [vcac_pkg::SUPPORT_W-1:0] SCHEME_SUPPORT = vcac_pkg::SUPPORT_VAL
) (
  // Clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  // Configuration access
  input  wire vcac_pkg::vcac_cfg_req_t       cfg_req_in,
  output var  vcac_pkg::vcac_cfg_rsp_t       cfg_rsp_out,
  // Capability word and scheme check for the control register
  output var  logic [vcac_pkg::DATA_W-1:0]   capability_out,
  input  wire logic [vcac_pkg::CHOICE_W-1:0] arbitration_scheme_choice_in,
  output var  logic                          choice_supported_out
);
  import vcac_pkg::*;

  // ==========================================================================
  // Field view of the held word
  // ==========================================================================
  logic [DATA_W-1:0]    assembled_word;
  wire  [TBL_POS_W-1:0] arbitration_table_position;
  wire  [SLOTS_W-1:0]   time_slot_field;
  wire                  reserved_high_bit;
  wire                  snoop_reject_flag;
  wire                  switched_traffic_only_flag;
  wire  [RSVD_LO_W-1:0] reserved_low_field;
  wire  [SUPPORT_W-1:0] arbitration_scheme_support;

  // Constant word; kept outside this file so field packing is reviewed in one place
  vcac_word_build #(
    .TABLE_POSITION (TABLE_POSITION),
    .TIME_SLOTS     (TIME_SLOTS),
    .SCHEME_SUPPORT (SCHEME_SUPPORT)
  ) u_word_build (
    .word_out (assembled_word)
  );

  // Field slices of the registered word, used by the choice check and checks below
  assign arbitration_table_position = capability_out[TBL_POS_LSB +: TBL_POS_W];
  assign reserved_high_bit          = capability_out[RSVD_HI_BIT];
  assign time_slot_field            = capability_out[SLOTS_LSB +: SLOTS_W];
  assign snoop_reject_flag          = capability_out[SNOOP_BIT];
  assign switched_traffic_only_flag = capability_out[SWITCHED_BIT];
  assign reserved_low_field         = capability_out[RSVD_LO_LSB +: RSVD_LO_W];
  assign arbitration_scheme_support = capability_out[SUPPORT_LSB +: SUPPORT_W];

  // ==========================================================================
  // Address decode
  // ==========================================================================
  wire                addr_match;
  wire                read_hit;
  wire                write_hit;
  logic [DATA_W-1:0]  next_capability;
  vcac_cfg_rsp_t      next_rsp;
  logic               next_choice_supported;

  // Byte lanes within the dword do not matter for a read-only word
  assign addr_match = cfg_req_in.addr[ADDR_W-1:WORD_LSB] == CAP_OFFSET[ADDR_W-1:WORD_LSB];
  assign read_hit   = cfg_req_in.valid && !cfg_req_in.write && addr_match;
  assign write_hit  = cfg_req_in.valid &&  cfg_req_in.write && addr_match;

  // ==========================================================================
  // Next values
  // ==========================================================================
  // Held word never takes write data; the write path simply does not exist
  assign next_capability = assembled_word;

  // Every request is answered next cycle; misses answer zero with hit low
  assign next_rsp = '{ack:   cfg_req_in.valid,
                      hit:   read_hit || write_hit,
                      rdata: read_hit ? capability_out : '0};

  // Lets control logic refuse a choice whose mask bit is clear
  assign next_choice_supported = arbitration_scheme_support[arbitration_scheme_choice_in];

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Reset value equals the constant word, so reads match in and after reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capability_out <= CAP_RESET;
    end else begin
      capability_out <= next_capability;
    end
  end

  // Configuration answer
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_rsp_out <= '0;
    end else begin
      cfg_rsp_out <= next_rsp;
    end
  end

  // Default choice after reset is fixed round-robin, bit 0 of the mask
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      choice_supported_out <= SUPPORT_VAL[SUPPORT_LSB];
    end else begin
      choice_supported_out <= next_choice_supported;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock_in);
  endclocking

  default disable iff (!rst_n_in);

  // Request shapes
  sequence cap_read_s;
    read_hit;
  endsequence

  sequence cap_write_s;
    write_hit;
  endsequence

  sequence miss_s;
    cfg_req_in.valid && !addr_match;
  endsequence

  sequence word_answer_s;
    cfg_rsp_out.ack && cfg_rsp_out.hit && (cfg_rsp_out.rdata == CAP_RESET);
  endsequence

  // Held word is always the documented constant
  word_value_a: assert property (capability_out == CAP_RESET)
    else $error("capability word differs from its fixed value");

  // A read returns the full word one cycle later
  read_answer_a: assert property (cap_read_s |=> word_answer_s)
    else $error("read of capability word answered wrongly");

  // A write followed at once by a read changes nothing, and that read still sees the word
  write_ignored_a: assert property (
    cap_write_s ##1 cap_read_s |=> word_answer_s and $stable(capability_out))
    else $error("write altered the capability word");

  // Write answer carries no data but is acknowledged as a hit
  write_answer_a: assert property (
    cap_write_s |=> cfg_rsp_out.ack && cfg_rsp_out.hit && (cfg_rsp_out.rdata == '0))
    else $error("write to capability word answered wrongly");

  // Other offsets answer zero and do not claim the access
  miss_answer_a: assert property (
    miss_s |=> cfg_rsp_out.ack && !cfg_rsp_out.hit && (cfg_rsp_out.rdata == '0))
    else $error("unmapped access answered wrongly");

  // Idle cycles produce no answer
  idle_quiet_a: assert property (!cfg_req_in.valid |=> !cfg_rsp_out.ack)
    else $error("answer without request");

  // Table position scaled by its unit gives the table start in bytes
  table_position_a: assert property (
    (int'(arbitration_table_position) * TBL_UNIT_BYTES == TBL_BYTES)
    && (arbitration_table_position == TBL_POS_VAL))
    else $error("arbitration table position wrong");

  // Reserved bit above the time-slot field
  rsvd_high_zero_a: assert property (reserved_high_bit == 1'h0)
    else $error("reserved bit 23 not zero");

  // Time-slot field holds the slot count minus one
  time_slots_a: assert property (int'(time_slot_field) + 1 == SLOTS_COUNT)
    else $error("time slot count wrong");

  // Snoop rejection has no meaning here
  snoop_zero_a: assert property (!snoop_reject_flag)
    else $error("snoop rejection bit set");

  // Channel carries all traffic
  switched_zero_a: assert property (!switched_traffic_only_flag)
    else $error("switched traffic only bit set");

  // Reserved field below the flags
  rsvd_low_zero_a: assert property (reserved_low_field == '0)
    else $error("reserved bits 13:8 not zero");

  // Exactly the fixed and time-based 128-phase schemes are advertised
  support_mask_a: assert property (
    arbitration_scheme_support ==
      ((SUPPORT_W'(1) << VCAC_FIXED_RR) | (SUPPORT_W'(1) << VCAC_TWRR_128)))
    else $error("arbitration support mask wrong");

  // Reserved mask bits and the unsupported 32- and 256-phase weighted schemes stay clear
  support_reserved_a: assert property (
    !arbitration_scheme_support[VCAC_RSVD_6] && !arbitration_scheme_support[VCAC_RSVD_7]
    && !arbitration_scheme_support[VCAC_WRR_32] && !arbitration_scheme_support[VCAC_WRR_256])
    else $error("reserved or unsupported scheme bit set");

  // Helper: choice seen by the check one cycle earlier
  logic [CHOICE_W-1:0] arbitration_scheme_choice_in_d;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arbitration_scheme_choice_in_d <= VCAC_FIXED_RR;
    end else begin
      arbitration_scheme_choice_in_d <= arbitration_scheme_choice_in;
    end
  end

  // Choice check follows the mask bit at the chosen position one cycle later
  choice_check_a: assert property (
    ##1 choice_supported_out ==
      ((arbitration_scheme_choice_in_d == VCAC_FIXED_RR)
       || (arbitration_scheme_choice_in_d == VCAC_TWRR_128)))
    else $error("scheme choice check wrong");

endmodule : vcac_capability
`default_nettype wire

// ### vcac_testbench.sv
// Self-checking testbench for the VC1 arbitration capability word
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import vcac_pkg::*;

  // ==========================================================================
  // Expected word, assembled field by field
  // ==========================================================================
  localparam logic [31:0] EXP_WORD = {8'h07,
                                      1'b0,
                                      7'h7F,
                                      1'b0,
                                      1'b0,
                                      6'h00,
                                      8'h11};

  // One noted answer: the cycle it is due in and what it must carry
  typedef struct packed {
    int          due;
    logic        hit;
    logic [31:0] rdata;
  } vcac_tb_note_t;

  logic            clock_in;
  logic            rst_n_in;
  vcac_cfg_req_t   cfg_req;
  vcac_cfg_rsp_t   cfg_rsp;
  logic [31:0]     capability;
  logic [2:0]      choice;
  logic            choice_supported;
  logic [2:0]      choice_q;
  logic            choice_due;
  int              miscompares;
  int              n_tests;
  int              cycle;
  int              seed;
  vcac_tb_note_t   notes[$];
  vcac_tb_note_t   note;

  vcac_capability dut (
    .clock_in                     (clock_in),
    .rst_n_in                     (rst_n_in),
    .cfg_req_in                   (cfg_req),
    .cfg_rsp_out                  (cfg_rsp),
    .capability_out               (capability),
    .arbitration_scheme_choice_in (choice),
    .choice_supported_out         (choice_supported)
  );

  // ==========================================================================
  // Clock, cycle count and choice history
  // ==========================================================================
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Remember the choice each edge took, so the monitor knows what to expect
  always @(posedge clock_in) begin
    cycle      <= cycle + 1;
    choice_q   <= choice;
    choice_due <= rst_n_in;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One request; the answer is worked out here from the address decode
  task automatic cfg(input logic write, input logic [11:0] addr);
    vcac_tb_note_t n;
    cfg_req.valid = 1'b1;
    cfg_req.write = write;
    cfg_req.addr  = addr;
    cfg_req.wdata = $random(seed);
    cfg_req.be    = 4'($random(seed));
    n.due   = cycle + 1;
    n.hit   = (addr[11:2] == 10'h05B);
    n.rdata = (n.hit && !write) ? EXP_WORD : 32'h0;
    notes.push_back(n);
    @(posedge clock_in);
    #1;
  endtask : cfg

  task automatic idle(input int n);
    cfg_req.valid = 1'b0;
    repeat (n) @(posedge clock_in);
    #1;
  endtask : idle

  task automatic end_test(input string name);
    $display("test %s done, %0d compares, %0d wrong", name, n_tests, miscompares);
  endtask : end_test

  task automatic finish_test;
    $display("compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Monitor: outputs are settled by the falling edge
  // ==========================================================================
  always @(negedge clock_in) begin
    check(64'(capability), 64'(EXP_WORD));
    if (rst_n_in !== 1'b1) begin
      check(64'(cfg_rsp), 64'h0);
      check(64'(choice_supported), 64'h1);
    end else begin
      if (choice_due === 1'b1)
        check(64'(choice_supported), 64'(EXP_WORD[choice_q]));
      if (cfg_rsp.ack === 1'b1 && notes.size() > 0) begin
        note = notes.pop_front();
        check(64'(cycle), 64'(note.due));
        check(64'({cfg_rsp.hit, cfg_rsp.rdata}), 64'({note.hit, note.rdata}));
      end else begin
        check(64'(cfg_rsp), 64'h0);
      end
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed     = 8302;
    cycle    = 0;
    rst_n_in = 1'b0;
    cfg_req  = '0;
    choice   = 3'h0;
    miscompares = 0;
    n_tests  = 0;
    repeat (2) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    // Read at the first edge allowed after reset
    cfg(1'b0, 12'h16C);
    idle(2);
    end_test("read");
    // Writes with every byte lane offset, each followed at once by a read
    for (int i = 0; i < 8; i++) begin
      cfg(1'b1, {10'h05B, 2'(i)});
      cfg(1'b0, {10'h05B, 2'(i + 1)});
    end
    idle(2);
    end_test("write");
    // Neighbouring addresses must miss and return zero; random addresses are checked against the decode
    cfg(1'b0, 12'h168);
    cfg(1'b0, 12'h170);
    cfg(1'b0, 12'h96C);
    cfg(1'b1, 12'hFFF);
    for (int i = 0; i < 40; i++)
      cfg(1'($random(seed)), 12'($random(seed)));
    idle(2);
    end_test("decode");
    // Every scheme position, then random choices under traffic
    for (int i = 0; i < 48; i++) begin
      choice = (i < 8) ? 3'(i) : 3'($random(seed));
      cfg(1'($random(seed)), (i % 3 == 0) ? 12'h16C : 12'($random(seed)));
    end
    idle(2);
    end_test("scheme");
    // Reset in mid-run leaves the word untouched
    rst_n_in = 1'b0;
    choice   = 3'h3;
    idle(2);
    rst_n_in = 1'b1;
    cfg(1'b0, 12'h16C);
    idle(3);
    check(64'(notes.size()), 64'h0);
    end_test("reset");
    finish_test();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #(4000 * 8);
    miscompares++;
    finish_test();
  end

endmodule : testbench
`default_nettype wire
